// ---- gpab_defines.vh ----
// Constants for the dual GPIO port block: register byte addresses,
// reset values, field positions and timing counts.
// Assumes a 32-bit APB with byte addresses on paddr[7:0].
`ifndef GPAB_DEFINES_VH
`define GPAB_DEFINES_VH

// ==========================================================
// Register byte addresses
`define GPAB_ADDR_A_PIN      8'h00
`define GPAB_ADDR_A_LATCH    8'h04
`define GPAB_ADDR_A_DIR      8'h08
`define GPAB_ADDR_ANALOG_SEL 8'h0C
`define GPAB_ADDR_B_PIN      8'h10
`define GPAB_ADDR_B_LATCH    8'h14
`define GPAB_ADDR_B_DIR      8'h18
`define GPAB_ADDR_ICTL1      8'h1C
`define GPAB_ADDR_ICTL2      8'h20
`define GPAB_ADDR_ICTL3      8'h24
`define GPAB_ADDR_ODCTL1     8'h28
`define GPAB_ADDR_DEVCFG     8'h2C

// ==========================================================
// Reset values
`define GPAB_RST_LATCH       8'h00
`define GPAB_RST_DIR         8'hFF
`define GPAB_RST_ANALOG_SEL  8'hFF
`define GPAB_RST_ICTL1       8'h00
`define GPAB_RST_ICTL2       8'hFF
`define GPAB_RST_ICTL3       8'h00
`define GPAB_RST_ODCTL1      8'h00
`define GPAB_RST_DEVCFG      8'h00

// ==========================================================
// Field positions and masks
`define GPAB_CHG_FLAG_BIT    0
`define GPAB_CHG_IE_BIT      3
`define GPAB_PULLUP_DIS_BIT  7
`define GPAB_CCP2_OD_BIT     6
`define GPAB_ODCTL1_MASK     8'hE1
`define GPAB_CFG_OSC_LSB     0
`define GPAB_CFG_OSC_PINFN   2
`define GPAB_CFG_CLKOUT      3
`define GPAB_CFG_CCP2_SEL    4
`define GPAB_CFG_EXT_MCU     5
`define GPAB_DEVCFG_MASK     8'h3F

// Oscillator modes in devcfg[1:0]
`define GPAB_OSC_INTERNAL    2'h0
`define GPAB_OSC_CRYSTAL     2'h1
`define GPAB_OSC_EXTCLK      2'h2

// ==========================================================
// Timing: instruction cycle is four oscillator clocks
`define GPAB_CYC_DIV         4
`define GPAB_CYC_HALF        2'h1

`endif

// ---- gpab_port.v ----
// Dual 8-bit GPIO port block (ports A and B) with APB register access.
// Assumes pin inputs synchronous to clk; pad drivers resolve out/oe.
//
// Behaviour
// - Port A has eight two-way pins, each with latch and direction bit.
// - Port A direction bit keeps driving control while analog select is on.
// - After reset A0-A3 and A5 are analog reading zero; A4 digital input.
// - Analog mode kills digital input path; digital output stays latch-driven.
// - External oscillator modes: A6/A7 not digital, their latch/direction read zero.
// - Internal oscillator modes: A6/A7 become ordinary digital I/O.
// - External-clock or internal modes: A6 may output oscillator clock divided by four.
// - Pin-function config bit set disables A6/A7 digital input and output.
// - Port B has eight two-way digital pins with latch and direction bits.
// - Clearing the pull-up disable bit enables all port B weak pull-ups.
// - A port B pull-up turns off while its direction bit selects output.
// - Reset leaves all port B pull-ups disabled.
// - B4-B7 detect change; output pins are excluded from comparison.
// - Inputs compare to snapshot from last port B pin data read or write; mismatches ORed set flag.
// - Mismatch keeps setting flag; port B pin data access refreshes snapshot, then flag clearable.
// - Port B change can wake the device from low-power modes.
// - CCP2 select cleared in extended mode: CCP2 output drives B3 over latch.
// - Reading a latch register returns the stored latch, not pin level.
//
// Decided for this implementation: register access over APB and the register addresses.
`include "gpab_defines.vh"

module gpab_port (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  portAIn,
    output reg  [7:0]  portAOut,
    output reg  [7:0]  portAOe,
    output reg  [7:0]  portAAnalog,
    input  wire [7:0]  portBIn,
    output reg  [7:0]  portBOut,
    output reg  [7:0]  portBOe,
    output reg  [7:0]  portBPullupEn,
    input  wire        ccpTwoOut,
    output reg         changeWake
);

    // ======================================================
    // Registers
    reg  [7:0] outLatchA_reg;
    reg  [7:0] dirA_reg;
    reg  [7:0] analogSel_reg;
    reg  [7:0] outLatchB_reg;
    reg  [7:0] dirB_reg;
    reg  [7:0] intCtl1_reg;
    reg  [7:0] intCtl2_reg;
    reg  [7:0] intCtl3_reg;
    reg  [7:0] odCtl1_reg;
    reg  [7:0] devCfg_reg;
    reg  [3:0] changeSnap_reg;
    reg  [1:0] cycDiv_reg;
    reg        cycClk_reg;

    // Register map (byte address, value in the low byte of the word):
    // 00 port A pin data   04 port A latch    08 port A direction
    // 0C analog select     10 port B pin data 14 port B latch
    // 18 port B direction  1C control one     20 control two
    // 24 control three     28 open-drain one  2C device configuration
    // Unmapped addresses answer with pslverr and read zero
    // Device configuration word:
    // [1:0] oscillator mode, [2] pin-function, [3] cycle clock on A6,
    // [4] channel two pin select, [5] extended mode

    // ======================================================
    // Bus decode
    wire       xferDone  = psel & penable & pready;
    wire       wrEn      = xferDone & pwrite;
    wire       rdEn      = xferDone & ~pwrite;
    wire [7:0] wData     = pwdata[7:0];
    wire       portBHit  = (paddr == `GPAB_ADDR_B_PIN);

    // ======================================================
    // Mode decode
    wire [1:0] oscMode   = devCfg_reg[`GPAB_CFG_OSC_LSB +: 2];
    wire       pinFnCfg  = devCfg_reg[`GPAB_CFG_OSC_PINFN];
    wire       ccpOwnsB3 = ~devCfg_reg[`GPAB_CFG_CCP2_SEL] & devCfg_reg[`GPAB_CFG_EXT_MCU];
    // A6/A7 are port pins only on an internal oscillator with the pin-function bit clear
    wire       digA67    = (oscMode == `GPAB_OSC_INTERNAL) & ~pinFnCfg;
    wire       clkOutSel = devCfg_reg[`GPAB_CFG_CLKOUT] &
                           ((oscMode == `GPAB_OSC_EXTCLK) | (oscMode == `GPAB_OSC_INTERNAL));

    // Analog-capable pins: A0-A3 on select bits 0-3, A5 on select bit 4
    wire [7:0] analogA   = {2'b00, analogSel_reg[4], 1'b0, analogSel_reg[3:0]};

    // Which port A pins behave as digital I/O at all
    wire [7:0] digPinA   = {digA67, digA67 & ~clkOutSel, 6'h3F};
    wire [7:0] digInEnA  = digPinA & ~analogA;

    // Latch and direction of A6/A7 read as zero when they are not port pins
    wire [7:0] visMaskA  = {digA67, digA67, 6'h3F};

    // ======================================================
    // Change detection on B4-B7
    wire [3:0] mismatch;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_chg
            // Output pins never take part in the comparison
            assign mismatch[gi] = dirB_reg[gi + 4] &
                                  (portBIn[gi + 4] ^ changeSnap_reg[gi]);
        end
    endgenerate
    wire       anyMismatch = |mismatch;

    // ======================================================
    // Read data
    reg  [7:0] readMux;
    reg        addrOk;
    always @* begin
        readMux = 8'h00;
        addrOk  = 1'b1;
        case (paddr)
            `GPAB_ADDR_A_PIN:    readMux = portAIn & digInEnA;
            `GPAB_ADDR_A_LATCH:  readMux = outLatchA_reg & visMaskA;
            `GPAB_ADDR_A_DIR:    readMux = dirA_reg & visMaskA;
            `GPAB_ADDR_ANALOG_SEL: readMux = analogSel_reg;
            `GPAB_ADDR_B_PIN:    readMux = portBIn;
            `GPAB_ADDR_B_LATCH:  readMux = outLatchB_reg;
            `GPAB_ADDR_B_DIR:    readMux = dirB_reg;
            `GPAB_ADDR_ICTL1:    readMux = intCtl1_reg;
            `GPAB_ADDR_ICTL2:    readMux = intCtl2_reg;
            `GPAB_ADDR_ICTL3:    readMux = intCtl3_reg;
            `GPAB_ADDR_ODCTL1:   readMux = odCtl1_reg;
            `GPAB_ADDR_DEVCFG:   readMux = devCfg_reg;
            default: begin
                readMux = 8'h00;
                addrOk  = 1'b0;
            end
        endcase
    end

    // ======================================================
    // APB answer: one wait state, data and error registered
    // Ready pulses once per access phase, so back-to-back transfers work
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // Read data holds between transfers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & penable & ~pready) begin
            prdata <= {24'h00_0000, readMux};
        end
    end

    // Error only ever stands beside ready
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & penable & ~pready & ~addrOk;
        end
    end

    // ======================================================
    // Register writes
    // One strobe per register except control one, high only at the completing edge
    wire       wrLatchA  = wrEn & ((paddr == `GPAB_ADDR_A_PIN) | (paddr == `GPAB_ADDR_A_LATCH));
    wire       wrDirA    = wrEn & (paddr == `GPAB_ADDR_A_DIR);
    wire       wrAnalog  = wrEn & (paddr == `GPAB_ADDR_ANALOG_SEL);
    wire       wrLatchB  = wrEn & ((paddr == `GPAB_ADDR_B_PIN) | (paddr == `GPAB_ADDR_B_LATCH));
    wire       wrDirB    = wrEn & (paddr == `GPAB_ADDR_B_DIR);
    wire       wrCtl2    = wrEn & (paddr == `GPAB_ADDR_ICTL2);
    wire       wrCtl3    = wrEn & (paddr == `GPAB_ADDR_ICTL3);
    wire       wrOdCtl   = wrEn & (paddr == `GPAB_ADDR_ODCTL1);
    wire       wrDevCfg  = wrEn & (paddr == `GPAB_ADDR_DEVCFG);
    wire       wrNone    = 1'b0;

    // Port A latch, through the latch word or the pin data word
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            outLatchA_reg <= `GPAB_RST_LATCH;
        end else if (wrLatchA) begin
            outLatchA_reg <= wData;
        end
    end

    // Hidden A6/A7 bits are kept, so they return when the pins are freed
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dirA_reg <= `GPAB_RST_DIR;
        end else if (wrDirA) begin
            dirA_reg <= wData;
        end
    end

    // Analog select, all analog-capable pins (A0-A3, A5) analog after reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            analogSel_reg <= `GPAB_RST_ANALOG_SEL;
        end else if (wrAnalog) begin
            analogSel_reg <= wData;
        end
    end

    // Port B latch, through the latch word or the pin data word
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            outLatchB_reg <= `GPAB_RST_LATCH;
        end else if (wrLatchB) begin
            outLatchB_reg <= wData;
        end
    end

    // Port B direction
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dirB_reg <= `GPAB_RST_DIR;
        end else if (wrDirB) begin
            dirB_reg <= wData;
        end
    end

    // Control two: pull-up disable set after reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            intCtl2_reg <= `GPAB_RST_ICTL2;
        end else if (wrCtl2) begin
            intCtl2_reg <= wData;
        end
    end

    // Control three is plain storage here
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            intCtl3_reg <= `GPAB_RST_ICTL3;
        end else if (wrCtl3 | wrNone) begin
            intCtl3_reg <= wData;
        end
    end

    // Open-drain control, reserved bits stay zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            odCtl1_reg <= `GPAB_RST_ODCTL1;
        end else if (wrOdCtl) begin
            odCtl1_reg <= wData & `GPAB_ODCTL1_MASK;
        end
    end

    // Device configuration, reserved bits stay zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            devCfg_reg <= `GPAB_RST_DEVCFG;
        end else if (wrDevCfg) begin
            devCfg_reg <= wData & `GPAB_DEVCFG_MASK;
        end
    end

    // ======================================================
    // Control register 1 and the change flag
    // A persisting mismatch beats a software clear in the same cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            intCtl1_reg <= `GPAB_RST_ICTL1;
        end else if (wrEn && paddr == `GPAB_ADDR_ICTL1) begin
            intCtl1_reg <= {wData[7:1], wData[0] | anyMismatch};
        end else if (anyMismatch) begin
            intCtl1_reg[`GPAB_CHG_FLAG_BIT] <= 1'b1;
        end
    end

    // Snapshot reloads on any port B pin data access, read or write
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            changeSnap_reg <= 4'h0;
        end else if ((rdEn | wrEn) & portBHit) begin
            changeSnap_reg <= portBIn[7:4];
        end
    end

    // ======================================================
    // Instruction cycle clock: clk divided by four
    // The square wave is pin data only, never used as a clock
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cycDiv_reg <= 2'h0;
        end else begin
            cycDiv_reg <= cycDiv_reg + 2'h1;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cycClk_reg <= 1'b0;
        end else if (cycDiv_reg == `GPAB_CYC_HALF || cycDiv_reg == 2'h3) begin
            cycClk_reg <= ~cycClk_reg;
        end
    end

    // ======================================================
    // Pin drivers, next values, one slice per pin
    wire [7:0] aOutNext;
    wire [7:0] aOeNext;
    wire [7:0] bOutNext;
    wire [7:0] bOeNext;
    wire [7:0] bPullNext;
    wire       pullupOn  = ~intCtl2_reg[`GPAB_PULLUP_DIS_BIT];
    wire       ccpOpenDr = odCtl1_reg[`GPAB_CCP2_OD_BIT];
    genvar pi;
    generate
        for (pi = 0; pi < 8; pi = pi + 1) begin : g_pin
            // Only A6 can carry the cycle clock, only B3 the channel output
            wire aIsClk = (pi == 6) && clkOutSel;
            wire bIsCcp = (pi == 3) && ccpOwnsB3;
            // Port A slice
            assign aOutNext[pi]  = aIsClk ? cycClk_reg : outLatchA_reg[pi];
            // Direction bit and digital-pin ownership gate the driver; analog select does not
            assign aOeNext[pi]   = aIsClk | (~dirA_reg[pi] & digPinA[pi]);
            // Port B slice; open-drain option only ever pulls low
            assign bOutNext[pi]  = bIsCcp ? (ccpTwoOut & ~ccpOpenDr) : outLatchB_reg[pi];
            assign bOeNext[pi]   = bIsCcp ? (~ccpOpenDr | ~ccpTwoOut) : ~dirB_reg[pi];
            // Pull-ups only on pins whose direction bit is set, only while the disable bit is low
            assign bPullNext[pi] = pullupOn & dirB_reg[pi];
        end
    endgenerate

    // ======================================================
    // Registered outputs
    // Port A pads
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            portAOut    <= 8'h00;
            portAOe     <= 8'h00;
            portAAnalog <= 8'h00;
        end else begin
            portAOut    <= aOutNext;
            portAOe     <= aOeNext;
            portAAnalog <= analogA;
        end
    end

    // Port B pads
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            portBOut      <= 8'h00;
            portBOe       <= 8'h00;
            portBPullupEn <= 8'h00;
        end else begin
            portBOut      <= bOutNext;
            portBOe       <= bOeNext;
            portBPullupEn <= bPullNext;
        end
    end

    // Wake follows the enabled flag, independent of global enable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            changeWake <= 1'b0;
        end else begin
            changeWake <= intCtl1_reg[`GPAB_CHG_FLAG_BIT] & intCtl1_reg[`GPAB_CHG_IE_BIT];
        end
    end

endmodule // gpab_port

// ---- gpab_port_chk.sv ----
// Checker for the dual GPIO port block, bound to its top module.
// Assumes one clock domain with an asynchronous active-high reset.
module gpab_port_chk (
    input logic        clk,
    input logic        rst,
    input logic        psel,
    input logic        penable,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [7:0]  portAOe,
    input logic [7:0]  portAAnalog,
    input logic [7:0]  portBOe,
    input logic [7:0]  portBPullupEn,
    input logic        changeWake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Bus handshake
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data above the low byte");
    // ==========================================
    // Pins
    pullup_out_a: assert property ((portBPullupEn & portBOe) == 8'h00)
        else $error("pull-up on a driven pin");
    pullup_group_a: assert property (portBPullupEn != 8'h00 |-> (portBPullupEn | portBOe) == 8'hFF)
        else $error("pull-ups not enabled together");
    reset_pullup_a: assert property ($past(rst) |-> portBPullupEn == 8'h00)
        else $error("pull-up on after reset");
    reset_analog_a: assert property ($past(rst) && !rst |=> portAAnalog == 8'h2F && portAOe == 8'h00)
        else $error("wrong pin setup after reset");
    analog_pins_a: assert property ((portAAnalog & 8'hD0) == 8'h00)
        else $error("analog mode on a digital-only pin");
    cover property (pready && pslverr);
    cover property ($rose(changeWake));
    cover property (portBPullupEn != 8'h00);
endmodule // gpab_port_chk

bind gpab_port gpab_port_chk i_gpab_port_chk (.clk, .rst, .psel, .penable, .prdata, .pready, .pslverr,
    .portAOe, .portAAnalog, .portBOe, .portBPullupEn, .changeWake);

// ---- gpab_pin_model.sv ----
// Board model: resolves every pad from the block's drive, pull-up and board level.
// Assumes board levels stand for undriven pins; a pull-up wins over a floating pin.
module gpab_pin_model (
    input  logic [7:0] portAOut,
    input  logic [7:0] portAOe,
    input  logic [7:0] portBOut,
    input  logic [7:0] portBOe,
    input  logic [7:0] portBPullupEn,
    input  logic [7:0] extA,
    input  logic [7:0] extB,
    output logic [7:0] portAIn,
    output logic [7:0] portBIn
);
    timeunit 1ns;
    timeprecision 1ps;
    assign portAIn = (portAOe & portAOut) | (~portAOe & extA);
    assign portBIn = (portBOe & portBOut) | (~portBOe & (portBPullupEn | extB));
endmodule // gpab_pin_model

// ---- gpab_port_bench.sv ----
// Self-checking bench for the dual GPIO port block over APB.
// Assumes the pin model closes the pad loop.
`include "gpab_defines.vh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module gpab_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        ccpTwoOut = 1'b0;
    logic [7:0]  extA = 8'hFF;
    logic [7:0]  extB = 8'h00;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, changeWake, err;
    logic [7:0]  portAIn, portAOut, portAOe, portAAnalog, portBIn, portBOut, portBOe, portBPullupEn;
    int          fail_count = 0;
    int          compares = 0;
    always #12.5 clk = ~clk;
    gpab_port i_gpab_port (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .portAIn, .portAOut, .portAOe, .portAAnalog, .portBIn, .portBOut, .portBOe,
        .portBPullupEn, .ccpTwoOut, .changeWake);
    gpab_pin_model i_gpab_pin_model (.portAOut, .portAOe, .portBOut, .portBOe, .portBPullupEn,
        .extA, .extB, .portAIn, .portBIn);
    // ==========================================
    // Bus tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, {24'h000000, exp}, rd)
    endtask
    // Registered pins show a cycle after the write lands
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // ==========================================
    // Scenarios
    task t_port_a;
        rdchk(`GPAB_ADDR_A_DIR, `GPAB_RST_DIR, "dir A");
        rdchk(`GPAB_ADDR_ANALOG_SEL, `GPAB_RST_ANALOG_SEL, "analog select");
        rdchk(`GPAB_ADDR_ICTL2, `GPAB_RST_ICTL2, "control two");
        rdchk(`GPAB_ADDR_A_PIN, 8'hD0, "pins A after reset");
        wr(`GPAB_ADDR_A_DIR, 8'h00);
        wr(`GPAB_ADDR_A_PIN, 8'h5A);
        settle;
        `CHK("A drive analog", 8'h5A, portAOut)
        `CHK("A enable analog", 8'hFF, portAOe)
        wr(`GPAB_ADDR_A_DIR, 8'hFF);
        wr(`GPAB_ADDR_ANALOG_SEL, 8'h00);
        @(posedge clk);
        extA <= 8'hFC;
        rdchk(`GPAB_ADDR_A_LATCH, 8'h5A, "latch A");
        rdchk(`GPAB_ADDR_A_PIN, 8'hFC, "pins A");
        $display("done port A");
    endtask
    task t_osc;
        int n;
        logic prev;
        wr(`GPAB_ADDR_A_LATCH, 8'hC3);
        wr(`GPAB_ADDR_A_DIR, 8'h00);
        wr(`GPAB_ADDR_DEVCFG, {6'h00, `GPAB_OSC_CRYSTAL});
        rdchk(`GPAB_ADDR_A_LATCH, 8'h03, "hidden latch");
        rdchk(`GPAB_ADDR_A_DIR, 8'h00, "hidden dir");
        `CHK("A enable crystal", 8'h3F, portAOe)
        wr(`GPAB_ADDR_DEVCFG, 8'h04);
        settle;
        `CHK("A enable pin cfg", 8'h3F, portAOe)
        wr(`GPAB_ADDR_DEVCFG, 8'h00);
        rdchk(`GPAB_ADDR_A_LATCH, 8'hC3, "latch internal");
        `CHK("A enable internal", 8'hFF, portAOe)
        wr(`GPAB_ADDR_DEVCFG, 8'h08);
        settle;
        n = 0;
        prev = portAOut[6];
        repeat (8) begin
            @(posedge clk);
            #1;
            if (portAOut[6] !== prev) n++;
            prev = portAOut[6];
        end
        `CHK("cycle clock edges", 4, n)
        wr(`GPAB_ADDR_DEVCFG, 8'h00);
        $display("done oscillator pins");
    endtask
    task t_port_b;
        wr(`GPAB_ADDR_B_DIR, 8'hF0);
        wr(`GPAB_ADDR_ICTL2, 8'h7F);
        settle;
        `CHK("pull-ups", 8'hF0, portBPullupEn)
        `CHK("B enable", 8'h0F, portBOe)
        rdchk(`GPAB_ADDR_B_PIN, 8'hF0, "pins B pulled");
        wr(`GPAB_ADDR_ICTL2, 8'hFF);
        wr(`GPAB_ADDR_B_DIR, 8'h7F);
        rdchk(`GPAB_ADDR_B_PIN, 8'h00, "pins B");
        wr(`GPAB_ADDR_ICTL1, 8'h08);
        wr(`GPAB_ADDR_B_LATCH, 8'h80);
        settle;
        rdchk(`GPAB_ADDR_ICTL1, 8'h08, "flag on driven pin");
        extB <= 8'h10;
        settle;
        rdchk(`GPAB_ADDR_ICTL1, 8'h09, "flag on change");
        `CHK("wake", 1'b1, changeWake)
        wr(`GPAB_ADDR_ICTL1, 8'h08);
        rdchk(`GPAB_ADDR_ICTL1, 8'h09, "flag in mismatch");
        rdchk(`GPAB_ADDR_B_PIN, 8'h90, "pins B reload");
        wr(`GPAB_ADDR_ICTL1, 8'h08);
        rdchk(`GPAB_ADDR_ICTL1, 8'h08, "flag cleared");
        settle;
        `CHK("wake off", 1'b0, changeWake)
        $display("done port B");
    endtask
    task t_ccp;
        wr(`GPAB_ADDR_B_DIR, 8'hF7);
        wr(`GPAB_ADDR_B_LATCH, 8'h00);
        wr(`GPAB_ADDR_DEVCFG, 8'h20);
        ccpTwoOut <= 1'b1;
        settle;
        `CHK("B3 from channel", 1'b1, portBOut[3])
        wr(`GPAB_ADDR_ODCTL1, 8'h40);
        settle;
        `CHK("B3 open drain enable", 1'b0, portBOe[3])
        `CHK("B3 open drain drive", 1'b0, portBOut[3])
        wr(`GPAB_ADDR_DEVCFG, 8'h30);
        settle;
        `CHK("B3 from latch", 1'b0, portBOut[3])
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("done channel and unmapped");
    endtask
    task t_reset;
        wr(`GPAB_ADDR_ICTL2, 8'h7F);
        settle;
        `CHK("pull-ups before reset", 8'hF7, portBPullupEn)
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(`GPAB_ADDR_ICTL2, `GPAB_RST_ICTL2, "control two after reset");
        `CHK("pull-ups after reset", 8'h00, portBPullupEn)
        rdchk(`GPAB_ADDR_ANALOG_SEL, `GPAB_RST_ANALOG_SEL, "analog after reset");
        $display("done mid-run reset");
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_port_a;
        t_osc;
        t_port_b;
        t_ccp;
        t_reset;
        close_out;
    end
    // About 215 cycles of traffic; over eighteen times that means a hang
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        close_out;
    end
endmodule // gpab_port_bench
